/* File: core/bbfeu_pkg.sv */
// Constants, opcodes and register map for the branch/bit/flag unit.
// Assumes a 32-bit APB master and a 16-bit instruction word.
package bbfeu_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [11:0] ADDR_INSTR  = 12'h000;
  localparam logic [11:0] ADDR_PC     = 12'h004;
  localparam logic [11:0] ADDR_SFLAGS = 12'h008;
  localparam logic [11:0] ADDR_STATUS = 12'h00C;
  localparam logic [4:0]  WIN_RF      = 5'h02;
  localparam logic [4:0]  WIN_IO      = 5'h04;
  localparam logic [15:0] PC_RESET    = 16'h0000;
  localparam logic [7:0]  SFLAGS_RESET = 8'h00;

  // ****************************************
  // Status flag bit positions
  // ****************************************
  localparam int FL_C = 0;
  localparam int FL_Z = 1;
  localparam int FL_N = 2;
  localparam int FL_V = 3;
  localparam int FL_S = 4;
  localparam int FL_H = 5;
  localparam int FL_T = 6;
  localparam int FL_I = 7;

  // ****************************************
  // Instruction fields: op[15:11] sel[10:8] addr[7:3] k[6:0]
  // ****************************************
  localparam int OP_HI = 15;
  localparam int OP_LO = 11;
  localparam int SEL_HI = 10;
  localparam int SEL_LO = 8;
  localparam int AD_HI = 7;
  localparam int AD_LO = 3;
  localparam int K_HI = 6;

  // ****************************************
  // Opcodes; dedicated flag set/clear use FSET/FCLR with a fixed sel
  // ****************************************
  localparam logic [4:0] OP_BRSET = 5'h00;
  localparam logic [4:0] OP_BRCLR = 5'h01;
  localparam logic [4:0] OP_BREQ = 5'h02;
  localparam logic [4:0] OP_BRNE = 5'h03;
  localparam logic [4:0] OP_BRCS = 5'h04;
  localparam logic [4:0] OP_BRCC = 5'h05;
  localparam logic [4:0] OP_BRSH = 5'h06;
  localparam logic [4:0] OP_BRLO = 5'h07;
  localparam logic [4:0] OP_BRMI = 5'h08;
  localparam logic [4:0] OP_BRPL = 5'h09;
  localparam logic [4:0] OP_BRGE = 5'h0A;
  localparam logic [4:0] OP_BRLT = 5'h0B;
  localparam logic [4:0] OP_BRHS = 5'h0C;
  localparam logic [4:0] OP_BRHC = 5'h0D;
  localparam logic [4:0] OP_BRTS = 5'h0E;
  localparam logic [4:0] OP_BRTC = 5'h0F;
  localparam logic [4:0] OP_BRVS = 5'h10;
  localparam logic [4:0] OP_BRVC = 5'h11;
  localparam logic [4:0] OP_BRIE = 5'h12;
  localparam logic [4:0] OP_BRID = 5'h13;
  localparam logic [4:0] OP_IOSET = 5'h14;
  localparam logic [4:0] OP_IOCLR = 5'h15;
  localparam logic [4:0] OP_SHL = 5'h16;
  localparam logic [4:0] OP_SHR = 5'h17;
  localparam logic [4:0] OP_ASHR = 5'h18;
  localparam logic [4:0] OP_ROTL = 5'h19;
  localparam logic [4:0] OP_ROTR = 5'h1A;
  localparam logic [4:0] OP_SWAP = 5'h1B;
  localparam logic [4:0] OP_TSTORE = 5'h1C;
  localparam logic [4:0] OP_TLOAD = 5'h1D;
  localparam logic [4:0] OP_FSET = 5'h1E;
  localparam logic [4:0] OP_FCLR = 5'h1F;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_FETCH  = 4'b0010,
    ST_EXEC   = 4'b0100,
    ST_SECOND = 4'b1000
  } bbfeu_state_type;

endpackage

/* File: core/bbfeu_mem_if.sv */
// Port bundle between the execute unit and a 32 x 8 storage block.
// Assumes one writer and one reader, both on the core clock.
`timescale 1ns/1ps
interface bbfeu_mem_if;
  logic [4:0] addr;
  logic       we;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport ctrl (output addr, output we, output wdata, input rdata);
  modport store (input addr, input we, input wdata, output rdata);
endinterface

/* File: core/bbfeu_mem.sv */
// 32 x 8 storage with registered read data, used for registers and I/O.
// Assumes the controller holds addr one cycle to read; write is immediate.
`timescale 1ns/1ps
module bbfeu_mem (
  // Clock and reset
  input  wire logic    ref_clk,
  input  wire logic    sys_rst,
  // Access port
  bbfeu_mem_if.store   port
);
  logic [7:0] mem_reg [32];
  logic [7:0] rdata_reg;

  // ****************************************
  // Storage
  // ****************************************
  // Contents are not reset; software loads them before use
  always_ff @(posedge ref_clk) begin
    if (port.we) begin
      mem_reg[port.addr] <= port.wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= mem_reg[port.addr];
    end
  end

  assign port.rdata = rdata_reg;
endmodule

/* File: core/bbfeu_top.sv */
// Branch, bit and status-flag execute unit with an APB register port.
// Assumes one APB master and that software writes one instruction at a time.
//
// Overview of operation
// - Branch on flag set: PC gets PC+k+1 when flag s is one; 1/2 cycles.
// - Branch on flag clear: PC gets PC+k+1 when flag s is zero.
// - Carry-set and lower take on C one; carry-clear and same-or-higher on C zero.
// - Signed greater-or-equal taken when N xor V is zero.
// - Signed less-than taken when N xor V is one, target PC+k+1.
// - Half-carry branches taken on H one or H zero.
// - Transfer-flag branches taken on T one or T zero.
// - Overflow branches taken on V one or V zero.
// - Interrupt branches test I; no branch changes any flag.
// - I/O bit set/clear force bit b of port P, two cycles, no flags.
// - Shifts fill 0 or keep bit 7, update Z C N V; swap touches no flag.
// - Rotate left: old C to bit 0, bit 7 to C, one cycle.
// - Rotate right: old C to bit 7, bit 0 to C, one cycle.
// - Bit store copies Rr bit b into T, only T changes.
// - Bit load copies T into Rd bit b, flags unchanged.
// - Flag set/clear by index or dedicated alias forces one flag only.
// - Interrupt enable sets I, disable clears I, one cycle each.
// - Signed-test set/clear forces S only, one cycle.
// - Half-carry set/clear force H only, one cycle.
//
// Chosen here: the register offsets and the APB register port.
`timescale 1ns/1ps
module bbfeu_top
  import bbfeu_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Execution state
  output logic             exec_busy,
  output logic [15:0]      prog_counter
);
  import bbfeu_pkg::*;

  // ****************************************
  // Helper functions
  // ****************************************
  function automatic logic is_branch(input logic [4:0] op);
    is_branch = (op <= OP_BRID);
  endfunction

  function automatic logic needs_operand(input logic [4:0] op);
    needs_operand = !is_branch(op) && (op != OP_FSET) && (op != OP_FCLR);
  endfunction

  function automatic logic in_window(input logic [11:0] a, input logic [4:0] w);
    in_window = (a[11:7] == w) && (a[1:0] == 2'b00);
  endfunction

  // Branch condition from opcode, index and flags
  function automatic logic branch_cond(input logic [4:0] op, input logic [2:0] s,
                                       input logic [7:0] f);
    logic nv;
    nv = f[FL_N] ^ f[FL_V];
    unique case (op)
      OP_BRSET: branch_cond = f[s];
      OP_BRCLR: branch_cond = !f[s];
      OP_BREQ: branch_cond = f[FL_Z];
      OP_BRNE: branch_cond = !f[FL_Z];
      OP_BRMI: branch_cond = f[FL_N];
      OP_BRPL: branch_cond = !f[FL_N];
      OP_BRCS, OP_BRLO: branch_cond = f[FL_C];
      OP_BRCC, OP_BRSH: branch_cond = !f[FL_C];
      OP_BRGE: branch_cond = !nv;
      OP_BRLT: branch_cond = nv;
      OP_BRHS: branch_cond = f[FL_H];
      OP_BRHC: branch_cond = !f[FL_H];
      OP_BRTS: branch_cond = f[FL_T];
      OP_BRTC: branch_cond = !f[FL_T];
      OP_BRVS: branch_cond = f[FL_V];
      OP_BRVC: branch_cond = !f[FL_V];
      OP_BRIE: branch_cond = f[FL_I];
      OP_BRID: branch_cond = !f[FL_I];
      default: branch_cond = 1'b0;
    endcase
  endfunction

  // ****************************************
  // State
  // ****************************************
  bbfeu_state_type state_reg, state_next;
  logic [15:0] instr_reg, instr_next;
  logic [15:0] pc_reg, pc_next;
  logic [7:0]  flags_reg, flags_next;
  logic [1:0]  cycles_reg, cycles_next;
  logic        taken_reg, taken_next;
  logic        busy_reg, busy_next;
  logic        pready_reg, pready_next;
  logic [31:0] prdata_reg, prdata_next;
  logic        pslverr_reg, pslverr_next;

  bbfeu_mem_if rf_port ();
  bbfeu_mem_if io_port ();

  bbfeu_mem u_rf (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .port    (rf_port)
  );

  bbfeu_mem u_io (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .port    (io_port)
  );

  // ****************************************
  // Decode and datapath
  // ****************************************
  logic [4:0]  op;
  logic [2:0]  sel;
  logic [4:0]  opnd_addr;
  logic [15:0] k_ext;
  logic        setup_ph;
  logic        done_ph;
  logic        apb_wr;
  logic        win_rf;
  logic        win_io;
  logic [7:0]  shift_res;
  logic        shift_c;

  assign op        = instr_reg[OP_HI:OP_LO];
  assign sel       = instr_reg[SEL_HI:SEL_LO];
  assign opnd_addr = instr_reg[AD_HI:AD_LO];
  assign k_ext     = {{9{instr_reg[K_HI]}}, instr_reg[K_HI:0]};
  assign setup_ph  = psel && !penable;
  assign done_ph   = psel && penable && pready_reg;
  assign apb_wr    = done_ph && pwrite && !pslverr_reg;
  assign win_rf    = in_window(paddr, WIN_RF);
  assign win_io    = in_window(paddr, WIN_IO);

  // Shift and rotate unit
  always_comb begin
    shift_res = rf_port.rdata;
    shift_c   = flags_reg[FL_C];
    unique case (op)
      OP_SHL: begin
        shift_res = {rf_port.rdata[6:0], 1'b0};
        shift_c   = rf_port.rdata[7];
      end
      OP_SHR: begin
        shift_res = {1'b0, rf_port.rdata[7:1]};
        shift_c   = rf_port.rdata[0];
      end
      OP_ASHR: begin
        shift_res = {rf_port.rdata[7], rf_port.rdata[7:1]};
        shift_c   = rf_port.rdata[0];
      end
      OP_ROTL: begin
        shift_res = {rf_port.rdata[6:0], flags_reg[FL_C]};
        shift_c   = rf_port.rdata[7];
      end
      OP_ROTR: begin
        shift_res = {flags_reg[FL_C], rf_port.rdata[7:1]};
        shift_c   = rf_port.rdata[0];
      end
      OP_SWAP: shift_res = {rf_port.rdata[3:0], rf_port.rdata[7:4]};
      default: shift_res = rf_port.rdata;
    endcase
  end

  // ****************************************
  // Execute sequencer
  // ****************************************
  always_comb begin
    state_next    = state_reg;
    instr_next    = instr_reg;
    pc_next       = pc_reg;
    flags_next    = flags_reg;
    cycles_next   = cycles_reg;
    taken_next    = taken_reg;
    busy_next     = busy_reg;
    rf_port.addr  = paddr[6:2];
    io_port.addr  = paddr[6:2];
    rf_port.we    = 1'b0;
    io_port.we    = 1'b0;
    rf_port.wdata = pwdata[7:0];
    io_port.wdata = pwdata[7:0];
    unique case (state_reg)
      ST_IDLE: begin
        // Storage is only reachable from the bus while idle
        rf_port.we = apb_wr && win_rf;
        io_port.we = apb_wr && win_io;
        if (apb_wr && (paddr == ADDR_PC)) begin
          pc_next = pwdata[15:0];
        end
        if (apb_wr && (paddr == ADDR_SFLAGS)) begin
          flags_next = pwdata[7:0];
        end
        if (apb_wr && (paddr == ADDR_INSTR)) begin
          instr_next  = pwdata[15:0];
          cycles_next = 2'd0;
          taken_next  = 1'b0;
          busy_next   = 1'b1;
          if (needs_operand(pwdata[OP_HI:OP_LO])) begin
            state_next = ST_FETCH;
          end else begin
            state_next = ST_EXEC;
          end
        end
      end
      ST_FETCH: begin
        // Read data is registered, so one cycle to present the operand
        rf_port.addr = opnd_addr;
        io_port.addr = opnd_addr;
        state_next   = ST_EXEC;
      end
      ST_EXEC: begin
        rf_port.addr  = opnd_addr;
        io_port.addr  = opnd_addr;
        rf_port.wdata = shift_res;
        io_port.wdata = io_port.rdata;
        cycles_next   = 2'd1;
        pc_next       = pc_reg + 16'h0001;
        state_next    = ST_IDLE;
        busy_next     = 1'b0;
        if (is_branch(op)) begin
          if (branch_cond(op, sel, flags_reg)) begin
            // Taken branch adds a second cycle
            pc_next    = pc_reg + k_ext + 16'h0001;
            taken_next = 1'b1;
            state_next = ST_SECOND;
            busy_next  = 1'b1;
          end
        end else begin
          unique case (op)
            OP_IOSET, OP_IOCLR: begin
              io_port.wdata      = io_port.rdata;
              io_port.wdata[sel] = (op == OP_IOSET);
              io_port.we         = 1'b1;
              state_next         = ST_SECOND;
              busy_next          = 1'b1;
            end
            // Shift flags Z C N V
            OP_SHL, OP_SHR, OP_ASHR, OP_ROTL, OP_ROTR: begin
              rf_port.we        = 1'b1;
              flags_next[FL_Z]  = (shift_res == 8'h00);
              flags_next[FL_C]  = shift_c;
              flags_next[FL_N]  = shift_res[7];
              flags_next[FL_V]  = shift_res[7] ^ shift_c;
            end
            OP_SWAP: rf_port.we = 1'b1;
            OP_TSTORE: flags_next[FL_T] = rf_port.rdata[sel];
            OP_TLOAD: begin
              rf_port.wdata      = rf_port.rdata;
              rf_port.wdata[sel] = flags_reg[FL_T];
              rf_port.we         = 1'b1;
            end
            OP_FSET: flags_next[sel] = 1'b1;
            OP_FCLR: flags_next[sel] = 1'b0;
            default: flags_next = flags_reg;
          endcase
        end
      end
      ST_SECOND: begin
        cycles_next = 2'd2;
        busy_next   = 1'b0;
        state_next  = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_reg  <= ST_IDLE;
      instr_reg  <= 16'h0000;
      pc_reg     <= PC_RESET;
      flags_reg  <= SFLAGS_RESET;
      cycles_reg <= 2'd0;
      taken_reg  <= 1'b0;
      busy_reg   <= 1'b0;
    end else begin
      state_reg  <= state_next;
      instr_reg  <= instr_next;
      pc_reg     <= pc_next;
      flags_reg  <= flags_next;
      cycles_reg <= cycles_next;
      taken_reg  <= taken_next;
      busy_reg   <= busy_next;
    end
  end

  // ****************************************
  // APB slave
  // ****************************************
  // Storage windows need one wait state for the registered read;
  // all other registers answer in the first access cycle.
  always_comb begin
    pready_next  = 1'b0;
    prdata_next  = prdata_reg;
    pslverr_next = 1'b0;
    if (setup_ph) begin
      if (win_rf || win_io) begin
        // Storage belongs to the sequencer while busy
        if (busy_reg) begin
          pready_next  = 1'b1;
          pslverr_next = 1'b1;
        end
      end else begin
        pready_next = 1'b1;
        prdata_next = 32'h0000_0000;
        unique case (paddr)
          ADDR_INSTR:  prdata_next[15:0] = instr_reg;
          ADDR_PC:     prdata_next[15:0] = pc_reg;
          ADDR_SFLAGS: prdata_next[7:0] = flags_reg;
          ADDR_STATUS: prdata_next[3:0] = {cycles_reg, taken_reg, busy_reg};
          default:     pslverr_next = 1'b1;
        endcase
        // Control writes during execution would tear the instruction
        if (pwrite && busy_reg && (paddr != ADDR_STATUS)) begin
          pslverr_next = 1'b1;
        end
      end
    end else if (psel && penable && !pready_reg) begin
      pready_next = 1'b1;
      prdata_next = {24'h00_0000, win_io ? io_port.rdata : rf_port.rdata};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= pready_next;
      prdata_reg  <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign pready       = pready_reg;
  assign prdata       = prdata_reg;
  assign pslverr      = pslverr_reg;
  assign exec_busy    = busy_reg;
  assign prog_counter = pc_reg;
endmodule

/* File: bench/bbfeu_chk.sv */
// Concurrent checks on the ports of the branch/bit/flag unit.
// Assumes bbfeu_pkg is compiled first and the bind below reaches bbfeu_top.
`timescale 1ns/1ps
module bbfeu_chk
  import bbfeu_pkg::*;
(
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  // APB slave side
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // Execution state
  input wire logic        exec_busy,
  input wire logic [15:0] prog_counter
);
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  wire xfer = psel && penable && pready;
  wire pc_wr = xfer && pwrite && paddr == ADDR_PC;

  property p_ready_one; pready |=> !pready; endproperty
  property p_ready_acc; pready |-> psel && penable; endproperty
  property p_err_ready; pslverr |-> pready; endproperty
  property p_rst_vals;
    $fell(sys_rst) |-> prog_counter == PC_RESET && !exec_busy && !pready;
  endproperty
  property p_instr_go; xfer && pwrite && paddr == ADDR_INSTR && !pslverr |=> exec_busy;
  endproperty
  property p_busy_ends; $rose(exec_busy) |-> ##[1:5] !exec_busy; endproperty
  // Only execution or a software write may move the counter
  property p_pc_hold; !exec_busy && !pc_wr |=> $stable(prog_counter); endproperty
  property p_pc_load; pc_wr && !pslverr |=> prog_counter == $past(pwdata[15:0]);
  endproperty
  property p_busy_ref; xfer && exec_busy && pwrite && paddr != ADDR_STATUS |-> pslverr;
  endproperty
  property p_unmap; xfer && paddr >= 12'h280 |-> pslverr; endproperty

  a_ready_one: assert property (p_ready_one) else $error("pready longer than one cycle");
  a_ready_acc: assert property (p_ready_acc) else $error("pready outside access phase");
  a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
  a_rst_vals: assert property (p_rst_vals) else $error("outputs not at reset values");
  a_instr_go: assert property (p_instr_go) else $error("instruction write did not start");
  a_busy_ends: assert property (p_busy_ends) else $error("execution too long");
  a_pc_hold: assert property (p_pc_hold) else $error("counter moved while idle");
  a_pc_load: assert property (p_pc_load) else $error("counter write lost");
  a_busy_ref: assert property (p_busy_ref) else $error("write while busy accepted");
  a_unmap: assert property (p_unmap) else $error("unmapped access accepted");

  c_err: cover property (xfer && pslverr);
  c_two: cover property ($rose(exec_busy) ##2 !exec_busy);
  c_one: cover property ($rose(exec_busy) ##1 !exec_busy);
endmodule

bind bbfeu_top bbfeu_chk u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .exec_busy(exec_busy), .prog_counter(prog_counter));

/* File: bench/tb_top.sv */
// Self-checking bench for the branch/bit/flag unit, driven over APB.
// Assumes bbfeu_pkg, the design files and bbfeu_chk are compiled first.
`timescale 1ns/1ps
module tb_top;
  import bbfeu_pkg::*;
  localparam logic [7:0] PATS [5] = '{8'h00, 8'hFF, 8'h0C, 8'h55, 8'hAA};
  localparam logic [7:0] VALS [3] = '{8'h81, 8'h80, 8'h01};
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        exec_busy;
  logic [15:0] prog_counter;
  int          errors = 0;
  int          checks_done = 0;

  always #50 ref_clk = ~ref_clk;

  bbfeu_top dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .exec_busy(exec_busy), .prog_counter(prog_counter));

  // ****************
  // Support tasks
  // ****************
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Leaves the request up so that a second transfer may follow at once
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      chk("pready", 32'h0000_0001, 32'h0000_0000);
      report_and_stop();
    end
    q = prdata;
    e = pslverr;
  endtask

  task automatic idle;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
    idle();
    chk("write_err", 32'h0000_0000, {31'h0, e});
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    idle();
  endtask

  task automatic wait_done(output logic [31:0] st);
    int n;
    n = 0;
    do begin
      rd(ADDR_STATUS, st);
      n++;
    end while (st[0] !== 1'b0 && n < 8);
    if (st[0] !== 1'b0) begin
      chk("busy", 32'h0000_0000, 32'h0000_0001);
      report_and_stop();
    end
  endtask

  task automatic run(input logic [15:0] ins, output logic [31:0] st);
    wr(ADDR_INSTR, {16'h0000, ins});
    wait_done(st);
  endtask

  function automatic logic [11:0] rf(input int n);
    return 12'h100 + 12'(n * 4);
  endfunction

  function automatic logic [11:0] io(input int n);
    return 12'h200 + 12'(n * 4);
  endfunction

  function automatic logic taken(input logic [4:0] op, input logic [2:0] s,
                                 input logic [7:0] f);
    logic b;
    case (op)
      OP_BRSET, OP_BRCLR: b = f[s];
      OP_BREQ, OP_BRNE: b = f[FL_Z];
      OP_BRCS, OP_BRCC, OP_BRSH, OP_BRLO: b = f[FL_C];
      OP_BRMI, OP_BRPL: b = f[FL_N];
      OP_BRGE, OP_BRLT: b = f[FL_N] ^ f[FL_V];
      OP_BRHS, OP_BRHC: b = f[FL_H];
      OP_BRTS, OP_BRTC: b = f[FL_T];
      OP_BRVS, OP_BRVC: b = f[FL_V];
      default: b = f[FL_I];
    endcase
    // Even codes test for one, except same-or-higher and greater-or-equal
    if (op inside {OP_BRSH, OP_BRLO, OP_BRGE, OP_BRLT}) begin
      return b == op[0];
    end
    return b == !op[0];
  endfunction

  // ****************
  // Scenarios
  // ****************
  task automatic t_reset;
    logic [31:0] q;
    rd(ADDR_PC, q);
    chk("reset_pc", {16'h0000, PC_RESET}, q);
    rd(ADDR_SFLAGS, q);
    chk("reset_flags", {24'h00_0000, SFLAGS_RESET}, q);
  endtask

  task automatic t_branches;
    logic [31:0] st, q;
    logic [6:0]  k;
    logic [2:0]  s;
    logic        tk;
    logic [15:0] pc_exp;
    for (int o = 0; o <= 19; o++) begin
      for (int i = 0; i < 5; i++) begin
        s = 3'(o + i);
        k = i[0] ? 7'h7D : 7'h05;
        tk = taken(5'(o), s, PATS[i]);
        pc_exp = tk ? 16'h0100 + {{9{k[6]}}, k} + 16'h0001 : 16'h0101;
        wr(ADDR_PC, 32'h0000_0100);
        wr(ADDR_SFLAGS, {24'h00_0000, PATS[i]});
        run({5'(o), s, 1'b0, k}, st);
        rd(ADDR_PC, q);
        chk("branch_pc", {16'h0000, pc_exp}, q);
        chk("branch_status", {28'h0, tk ? 2'h2 : 2'h1, tk, 1'b0}, {28'h0, st[3:0]});
        rd(ADDR_SFLAGS, q);
        chk("branch_flags", {24'h00_0000, PATS[i]}, q);
      end
    end
  endtask

  task automatic t_shifts;
    logic [7:0]  v, r, fin, fx;
    logic [31:0] st, q;
    logic        c;
    for (int o = 22; o <= 27; o++) begin
      for (int i = 0; i < 6; i++) begin
        v = VALS[i % 3];
        fin = 8'hF0 | 8'(i / 3);
        fx = fin;
        case (5'(o))
          OP_SHL: {c, r} = {v, 1'b0};
          OP_SHR: {r, c} = {1'b0, v};
          OP_ASHR: {r, c} = {v[7], v};
          OP_ROTL: {c, r} = {v, fin[FL_C]};
          OP_ROTR: {r, c} = {fin[FL_C], v};
          default: {c, r} = {fin[FL_C], v[3:0], v[7:4]};
        endcase
        if (o != 27) begin
          fx[FL_C] = c;
          fx[FL_Z] = (r == 8'h00);
          fx[FL_N] = r[7];
          fx[FL_V] = r[7] ^ c;
        end
        wr(rf(5), {24'h00_0000, v});
        wr(ADDR_SFLAGS, {24'h00_0000, fin});
        run({5'(o), 3'h0, 5'h05, 3'h0}, st);
        chk("shift_cycles", 32'h0000_0001, {30'h0, st[3:2]});
        rd(rf(5), q);
        chk("shift_result", {24'h00_0000, r}, q);
        rd(ADDR_SFLAGS, q);
        chk("shift_flags", {24'h00_0000, fx}, q);
      end
    end
  endtask

  task automatic t_bits;
    logic [31:0] st, q;
    wr(ADDR_SFLAGS, 32'h0000_00A5);
    wr(io(3), 32'h0000_005A);
    run({OP_IOSET, 3'h0, 5'h03, 3'h0}, st);
    chk("io_cycles", 32'h0000_0002, {30'h0, st[3:2]});
    run({OP_IOCLR, 3'h6, 5'h03, 3'h0}, st);
    rd(io(3), q);
    chk("io_bits", 32'h0000_001B, q);
    rd(ADDR_SFLAGS, q);
    chk("io_flags", 32'h0000_00A5, q);
    wr(ADDR_SFLAGS, 32'h0000_0000);
    wr(rf(7), 32'h0000_0004);
    run({OP_TSTORE, 3'h2, 5'h07, 3'h0}, st);
    rd(ADDR_SFLAGS, q);
    chk("tstore_flags", 32'h0000_0040, q);
    wr(ADDR_SFLAGS, 32'h0000_00BF);
    wr(rf(9), 32'h0000_00FF);
    run({OP_TLOAD, 3'h3, 5'h09, 3'h0}, st);
    rd(rf(9), q);
    chk("tload_reg", 32'h0000_00F7, q);
    rd(ADDR_SFLAGS, q);
    chk("tload_flags", 32'h0000_00BF, q);
  endtask

  task automatic t_flags;
    logic [31:0] st, q;
    for (int s = 0; s < 8; s++) begin
      wr(ADDR_SFLAGS, 32'h0000_0000);
      run({OP_FSET, 3'(s), 8'h00}, st);
      rd(ADDR_SFLAGS, q);
      chk("flag_set", 32'h0000_0001 << s, q);
      wr(ADDR_SFLAGS, 32'h0000_00FF);
      run({OP_FCLR, 3'(s), 8'h00}, st);
      rd(ADDR_SFLAGS, q);
      chk("flag_clear", 32'h0000_00FF ^ (32'h0000_0001 << s), q);
      chk("flag_cycles", 32'h0000_0001, {30'h0, st[3:2]});
    end
  endtask

  task automatic t_refuse;
    logic [31:0] st, q;
    logic        e;
    apb(1'b0, 12'h300, 32'h0000_0000, q, e);
    idle();
    chk("unmapped_err", 32'h0000_0001, {31'h0, e});
    wr(ADDR_STATUS, 32'h0000_00FF);
    rd(ADDR_STATUS, q);
    chk("status_ro", 32'h0000_0004, q);
    wr(ADDR_PC, 32'h0000_0200);
    // Back-to-back requests reach the unit while the bit operation still runs
    apb(1'b1, ADDR_INSTR, {16'h0000, OP_IOSET, 3'h2, 5'h03, 3'h0}, q, e);
    chk("instr_err", 32'h0000_0000, {31'h0, e});
    apb(1'b1, ADDR_PC, 32'h0000_4321, q, e);
    chk("busy_write_err", 32'h0000_0001, {31'h0, e});
    apb(1'b0, rf(5), 32'h0000_0000, q, e);
    idle();
    chk("busy_read_err", 32'h0000_0001, {31'h0, e});
    wait_done(st);
    rd(io(3), q);
    chk("busy_io_bits", 32'h0000_001F, q);
    rd(ADDR_PC, q);
    chk("busy_pc", 32'h0000_0201, q);
    rd(ADDR_INSTR, q);
    chk("instr_read", {16'h0000, OP_IOSET, 3'h2, 5'h03, 3'h0}, q);
  endtask

  initial begin
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    t_reset();
    t_branches();
    t_shifts();
    t_bits();
    t_flags();
    t_refuse();
    report_and_stop();
  end
endmodule
